// *** pkg/sdram_cfg_params.svh ***
// offsets, field positions, reset values and counts of the sdram interface block
`ifndef SDRAM_CFG_PARAMS_SVH
`define SDRAM_CFG_PARAMS_SVH
// How it works
// - after a single read wait the timing-one read turnaround before next command
// - after a single write wait the timing-one write turnaround before next command
// - read latency code selects cas latency: ddr 6=2, 7=2.5; sdr 2=2, 3=3
// - wait the activate-to-access delay between activate and read or write
// - enforce precharge-to-activate and refresh-to-activate delays
// - write latency is counted in half memory clock periods, unscaled in both sdr and ddr
// - sdr counts delays in whole memory clocks, ddr in half periods
// - timing-two sets burst read, burst write and burst read-to-write delays
// - control register is cleared by power-up reset only
// - mode register writes are ignored while mode enable is 0
// - control clock-enable bit drives the memory clock-enable pin through one register stage
// - control type bit: 0 sdr, 1 ddr
// - with refresh enabled, refresh every interval field times 64 memory clocks
// - drive bit: drive data only for writes, or always except for reads
// - port width bit selects 32 or 16 bit bus; the address mapping has its own select bit
// - each strobe gate bit lets its strobe be driven; 0 keeps it undriven
// - soft refresh bit issues one refresh soon, only when unlocked; reads 0
// - soft precharge bit issues precharge-all soon, only when unlocked; reads 0
// - mode register drives bank pins and address bits 11:0 of the command
// - mode write with command bit set issues load-mode on all chip selects
// - clock enable stays low until enabled, then a no-operation is driven
`define A_MODE      9'h100
`define A_CTRL      9'h104
`define A_TIM1      9'h108
`define A_TIM2      9'h10C
`define A_STAT      9'h110
`define A_SDLY      9'h190
`define CTRL_RST    32'h00000000
`define TIM_RST     32'h00000000
`define SDLY_RST    32'h00000000
`define CTRL_MASK   32'hF17F2F00
`define TIM1_MASK   32'hFFF77F70
`define TIM2_MASK   32'hFFFF0000
`define SDLY_MASK   32'h0000000F
`define CT_MODE_EN  31
`define CT_CKE      30
`define CT_DDR      29
`define CT_REF_EN   28
`define CT_UPPER_ADDRESS_MAP_SELECT  24
`define CT_DRIVE    22
`define CT_RINT     21:16
`define CT_PS       13
`define CT_DQS      11:8
`define CT_SREF     2
`define CT_SPRE     1
`define T1_SRD      31:28
`define T1_SWT      27:24
`define T1_RDL      23:20
`define T1_ACT      18:16
`define T1_PRE      14:12
`define T1_REF      11:8
`define T1_WRL      6:4
`define T2_BRD      31:28
`define T2_BWT      27:24
`define T2_BRW      23:20
`define MD_BA       31:30
`define MD_MA       29:18
`define MD_CMD      16
`define REF_LOG2    6
`define LMR_WAIT    8'h04
`define CL_SDR2     4'h2
`define CL_SDR3     4'h3
`define CL_DDR2     4'h6
`define CL_DDR25    4'h7
`define CLH_2       8'h04
`define CLH_25      8'h05
`define CLH_3       8'h06
`endif

// *** pkg/sdram_cfg_pkg.sv ***
// types of the sdram interface block: controller states and memory commands
package sdram_cfg_pkg;
   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_OPEN  = 3'b010,
      S_CLOSE = 3'b100
   } state_t;
   // ras_n, cas_n, we_n
   typedef enum logic [2:0] {
      CMD_LMR = 3'b000,
      CMD_REF = 3'b001,
      CMD_PRE = 3'b010,
      CMD_ACT = 3'b011,
      CMD_WR  = 3'b100,
      CMD_RD  = 3'b101,
      CMD_NOP = 3'b111
   } cmd_t;
endpackage

// *** verilog/sdram_interface_config.sv ***
// sdram configuration registers and command generator on the system clock, paced by the sampled memory clock
`include "sdram_cfg_params.svh"

module sdram_interface_config
   import sdram_cfg_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        soft_rst,
   input  wire logic [8:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        acc_req,
   input  wire logic        acc_we,
   input  wire logic        acc_burst,
   input  wire logic        acc_cs,
   input  wire logic [1:0]  acc_bank,
   input  wire logic [12:0] acc_row,
   input  wire logic [9:0]  acc_col,
   output logic             acc_done,
   input  wire logic        mem_clk_in,
   output logic             mem_cke,
   output logic      [1:0]  mem_cs_n,
   output logic             mem_ras_n,
   output logic             mem_cas_n,
   output logic             mem_we_n,
   output logic      [1:0]  bank_select_pins,
   output logic      [12:0] multiplexed_row_col_pins,
   output logic      [1:0]  mem_dq_oe,
   output logic      [3:0]  data_strobe_pins_oe
);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic        wait_q;
   logic [31:0] rdata_q;
   logic [31:0] ctrl_q;
   logic [31:0] tim1_q;
   logic [31:0] tim2_q;
   logic [31:0] sdly_q;
   logic        pre_pend_q;
   logic        lmr_pend_q;
   logic        ref_pend_q;
   logic [13:0] lmr_data_q;
   logic [2:0]  mck_q;
   logic [11:0] ref_cnt_q;
   state_t      state_q;
   logic [7:0]  dly_q;
   cmd_t        cmd_q;
   logic [1:0]  cs_n_q;
   logic [1:0]  open_cs_n_q;
   logic [1:0]  ba_q;
   logic [12:0] ma_q;
   logic        done_q;
   logic        rd_win_q;
   logic        wr_win_q;
   logic [1:0]  dq_oe_q;
   logic [3:0]  dqs_oe_q;
   logic        cke_q;
   logic        we_q;

   // ---------------- register bus ----------------
   logic [31:0] be_mask;
   logic [31:0] rd_mux;
   logic        wr_fire;
   logic        rd_take;

   assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wr_fire = avs_write & ~wait_q;
   assign rd_take = avs_read & wait_q;

   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = (old & ~be_mask) | (avs_writedata & be_mask);
   endfunction

   // one wait cycle per access, so the register path stays a single flop stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~((avs_read | avs_write) & wait_q);
      end
   end

   always_comb begin
      unique case (avs_address)
         `A_CTRL: rd_mux = ctrl_q;
         `A_TIM1: rd_mux = tim1_q;
         `A_TIM2: rd_mux = tim2_q;
         `A_SDLY: rd_mux = sdly_q;
         `A_STAT: rd_mux = {24'h000000, dly_q[3:0], pre_pend_q | lmr_pend_q,
                            state_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 32'h00000000;
      end else if (rd_take) begin
         rdata_q <= rd_mux;
      end
   end

   // only power-up reset reaches the control register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= `CTRL_RST;
      end else if (wr_fire && avs_address == `A_CTRL) begin
         ctrl_q <= merge(ctrl_q) & `CTRL_MASK;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tim1_q <= `TIM_RST;
         tim2_q <= `TIM_RST;
         sdly_q <= `SDLY_RST;
      end else if (soft_rst) begin
         tim1_q <= `TIM_RST;
         tim2_q <= `TIM_RST;
         sdly_q <= `SDLY_RST;
      end else if (wr_fire) begin
         if (avs_address == `A_TIM1) begin
            tim1_q <= merge(tim1_q) & `TIM1_MASK;
         end
         if (avs_address == `A_TIM2) begin
            tim2_q <= merge(tim2_q) & `TIM2_MASK;
         end
         if (avs_address == `A_SDLY) begin
            sdly_q <= merge(sdly_q) & `SDLY_MASK;
         end
      end
   end

   // ---------------- software command requests ----------------
   logic [31:0] wd;
   logic        ctrl_wr;
   logic        pre_set;
   logic        lmr_set;
   logic        ref_set;
   logic        ref_tmo;
   logic        go;
   logic        issue_pre;
   logic        issue_lmr;
   logic        issue_ref;
   logic        issue_act;
   logic        issue_rw;
   logic        issue_cls;

   assign wd      = avs_writedata & be_mask;
   assign ctrl_wr = wr_fire && avs_address == `A_CTRL && ctrl_q[`CT_MODE_EN];
   assign pre_set = ctrl_wr & wd[`CT_SPRE];
   assign ref_set = (ctrl_wr & wd[`CT_SREF]) | ref_tmo;
   assign lmr_set = wr_fire && avs_address == `A_MODE
                    && ctrl_q[`CT_MODE_EN] && wd[`MD_CMD];

   // a new request in the issuing cycle is kept: set wins over clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pre_pend_q <= 1'b0;
         lmr_pend_q <= 1'b0;
         ref_pend_q <= 1'b0;
      end else if (soft_rst) begin
         pre_pend_q <= 1'b0;
         lmr_pend_q <= 1'b0;
         ref_pend_q <= 1'b0;
      end else begin
         pre_pend_q <= pre_set | (pre_pend_q & ~issue_pre);
         lmr_pend_q <= lmr_set | (lmr_pend_q & ~issue_lmr);
         ref_pend_q <= ref_set | (ref_pend_q & ~issue_ref);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lmr_data_q <= 14'h0000;
      end else if (lmr_set) begin
         lmr_data_q <= {avs_writedata[`MD_BA], avs_writedata[`MD_MA]};
      end
   end

   // ---------------- memory clock sampling ----------------
   logic mck_rise;
   logic mck_edge;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mck_q <= 3'h0;
      end else begin
         mck_q <= {mck_q[1:0], mem_clk_in};
      end
   end

   assign mck_rise = mck_q[1] & ~mck_q[2];
   assign mck_edge = mck_q[1] ^ mck_q[2];

   // periodic refresh: interval field counts units of 64 memory clocks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ref_cnt_q <= 12'h000;
      end else if (!ctrl_q[`CT_REF_EN] || ref_tmo) begin
         ref_cnt_q <= 12'(ctrl_q[`CT_RINT]) << `REF_LOG2;
      end else if (mck_rise) begin
         ref_cnt_q <= ref_cnt_q - 12'h001;
      end
   end

   // firing at one, not zero, keeps the period at exactly interval times 64
   assign ref_tmo = ctrl_q[`CT_REF_EN] & mck_rise & (ref_cnt_q <= 12'h001);

   // ---------------- delay arithmetic ----------------
   // the wait counter runs on both memory clock edges, in half periods
   function automatic logic [7:0] hw(input logic [3:0] f);
      hw = ctrl_q[`CT_DDR] ? {4'h0, f} : {3'h0, f, 1'b0};
   endfunction

   logic [7:0] cl_half;
   logic [3:0] brd_max;
   logic [7:0] rw_dly;

   always_comb begin
      unique case (tim1_q[`T1_RDL])
         `CL_SDR2: cl_half = `CLH_2;
         `CL_SDR3: cl_half = `CLH_3;
         `CL_DDR2: cl_half = `CLH_2;
         `CL_DDR25: cl_half = ctrl_q[`CT_DDR] ? `CLH_25 : `CLH_3;
         default: cl_half = `CLH_3;
      endcase
   end

   // after a burst read the next access may be a write, so cover both delays
   assign brd_max = (tim2_q[`T2_BRD] > tim2_q[`T2_BRW]) ? tim2_q[`T2_BRD]
                                                        : tim2_q[`T2_BRW];

   always_comb begin
      if (acc_we) begin
         rw_dly = hw(acc_burst ? tim2_q[`T2_BWT] : tim1_q[`T1_SWT])
                  + {5'h00, tim1_q[`T1_WRL]};
      end else begin
         rw_dly = hw(acc_burst ? brd_max : tim1_q[`T1_SRD]) + cl_half;
      end
   end

   // ---------------- command sequencer ----------------
   // commands leave only with every delay run out; read or write from open, closing precharge from close, others from idle
   assign go        = mck_rise & (dly_q == 8'h00) & ctrl_q[`CT_CKE];
   assign issue_pre = go & (state_q == S_IDLE) & pre_pend_q;
   assign issue_lmr = go & (state_q == S_IDLE) & ~pre_pend_q & lmr_pend_q;
   assign issue_ref = go & (state_q == S_IDLE) & ~pre_pend_q & ~lmr_pend_q
                      & ref_pend_q;
   assign issue_act = go & (state_q == S_IDLE) & ~pre_pend_q & ~lmr_pend_q
                      & ~ref_pend_q & acc_req;
   assign issue_rw  = go & (state_q == S_OPEN);
   assign issue_cls = go & (state_q == S_CLOSE);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= S_IDLE;
      end else if (soft_rst) begin
         state_q <= S_IDLE;
      end else if (issue_act) begin
         state_q <= S_OPEN;
      end else if (issue_rw) begin
         state_q <= S_CLOSE;
      end else if (issue_cls) begin
         state_q <= S_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dly_q <= 8'h00;
      end else if (soft_rst) begin
         dly_q <= 8'h00;
      end else if (issue_act) begin
         dly_q <= hw({1'b0, tim1_q[`T1_ACT]});
      end else if (issue_rw) begin
         dly_q <= rw_dly;
      end else if (issue_pre || issue_cls) begin
         dly_q <= hw({1'b0, tim1_q[`T1_PRE]});
      end else if (issue_ref) begin
         dly_q <= hw(tim1_q[`T1_REF]);
      end else if (issue_lmr) begin
         dly_q <= `LMR_WAIT;
      end else if (mck_edge && dly_q != 8'h00) begin
         dly_q <= dly_q - 8'h01;
      end
   end

   // a command stands for one memory clock period, then no-operation
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_q  <= CMD_NOP;
         cs_n_q <= 2'h3;
         open_cs_n_q <= 2'h3;
         ba_q   <= 2'h0;
         ma_q   <= 13'h0000;
      end else if (issue_pre) begin
         cmd_q  <= CMD_PRE;
         cs_n_q <= 2'h0;
         ma_q   <= 13'h0400;
      end else if (issue_lmr) begin
         cmd_q  <= CMD_LMR;
         cs_n_q <= 2'h0;
         ba_q   <= lmr_data_q[13:12];
         ma_q   <= {1'b0, lmr_data_q[11:0]};
      end else if (issue_ref) begin
         cmd_q  <= CMD_REF;
         cs_n_q <= 2'h0;
      end else if (issue_act) begin
         cmd_q  <= CMD_ACT;
         cs_n_q <= acc_cs ? 2'h1 : 2'h2;
         open_cs_n_q <= acc_cs ? 2'h1 : 2'h2;
         ba_q   <= acc_bank;
         // top row pin only carries address in the upper mapping
         ma_q   <= {acc_row[12] & ctrl_q[`CT_UPPER_ADDRESS_MAP_SELECT], acc_row[11:0]};
      end else if (issue_rw) begin
         // access and closing precharge go to the chip that took the activate
         cmd_q  <= acc_we ? CMD_WR : CMD_RD;
         cs_n_q <= open_cs_n_q;
         ma_q   <= {3'h0, acc_col};
      end else if (issue_cls) begin
         cmd_q  <= CMD_PRE;
         cs_n_q <= open_cs_n_q;
         ma_q   <= 13'h0000;
      end else if (mck_rise) begin
         cmd_q  <= CMD_NOP;
         cs_n_q <= 2'h3;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         done_q <= 1'b0;
         we_q   <= 1'b0;
      end else begin
         done_q <= issue_rw;
         we_q   <= issue_rw ? acc_we : we_q;
      end
   end

   // data windows run from the read or write until the precharge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_win_q <= 1'b0;
         wr_win_q <= 1'b0;
      end else if (issue_rw) begin
         rd_win_q <= ~acc_we;
         wr_win_q <= acc_we;
      end else if (issue_cls || soft_rst) begin
         rd_win_q <= 1'b0;
         wr_win_q <= 1'b0;
      end
   end

   // ---------------- pin drive ----------------
   logic drive_now;

   // drive-always keeps unterminated lines from floating between reads
   assign drive_now = ctrl_q[`CT_DRIVE] ? ~rd_win_q : wr_win_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dq_oe_q  <= 2'h0;
         dqs_oe_q <= 4'h0;
         cke_q    <= 1'b0;
      end else begin
         dq_oe_q  <= {drive_now, drive_now & ~ctrl_q[`CT_PS]};
         dqs_oe_q <= {4{drive_now}} & ctrl_q[`CT_DQS];
         cke_q    <= ctrl_q[`CT_CKE];
      end
   end

   assign avs_readdata             = rdata_q;
   assign avs_waitrequest          = wait_q;
   assign acc_done                 = done_q;
   assign mem_cke                  = cke_q;
   assign mem_cs_n                 = cs_n_q;
   assign {mem_ras_n, mem_cas_n, mem_we_n} = cmd_q;
   assign bank_select_pins         = ba_q;
   assign multiplexed_row_col_pins = ma_q;
   assign mem_dq_oe                = dq_oe_q;
   assign data_strobe_pins_oe      = dqs_oe_q;

   // ---------------- checks ----------------
   sequence s_act;
      issue_act;
   endsequence

   sequence s_locked_mode_write;
      wr_fire && avs_address == `A_MODE && !ctrl_q[`CT_MODE_EN] && !lmr_pend_q;
   endsequence

   AST_MODE_LOCKED: assert property (
      s_locked_mode_write |=> !lmr_pend_q)
      else $error("mode write took effect while locked");

   AST_LMR_ALL_CS: assert property (
      issue_lmr |=> mem_cs_n == 2'h0 && !mem_ras_n && !mem_cas_n && !mem_we_n)
      else $error("load-mode not on both chip selects");

   AST_ACT_DELAY: assert property (
      s_act |=> dly_q == (ctrl_q[`CT_DDR] ? {5'h00, $past(tim1_q[`T1_ACT])}
                                          : {4'h0, $past(tim1_q[`T1_ACT]), 1'b0})
                && state_q == S_OPEN)
      else $error("activate delay not loaded");

   AST_NO_CMD_IN_DELAY: assert property (
      dly_q != 8'h00 && mck_rise |=> mem_cs_n == 2'h3)
      else $error("command issued before delay ran out");

   AST_CKE_FOLLOWS: assert property (
      $rose(ctrl_q[`CT_CKE]) |=> mem_cke ##0 $past(mem_cke) == 1'b0)
      else $error("clock enable did not follow control");

   AST_REF_TIMEOUT: assert property (
      ref_tmo |=> ref_pend_q && ref_cnt_q == 12'(ctrl_q[`CT_RINT]) << `REF_LOG2)
      else $error("periodic refresh not requested");

   AST_SOFT_BITS_ZERO: assert property (
      rd_take && avs_address == `A_CTRL |=> avs_readdata[2:1] == 2'h0)
      else $error("soft command bits read non-zero");

   AST_STROBE_GATE: assert property (
      (data_strobe_pins_oe & ~$past(ctrl_q[`CT_DQS])) == 4'h0)
      else $error("gated strobe driven");

   AST_SDR_DOUBLES: assert property (
      issue_ref && !ctrl_q[`CT_DDR] |=> dly_q == {3'h0, $past(tim1_q[`T1_REF]), 1'b0})
      else $error("sdr delay not in whole clocks");

   // seven quiet cycles fit a memory clock of eight system clocks
   sequence s_ref_next_rise;
      issue_ref ##1 (!mck_rise)[*7] ##1 (mck_rise && dly_q != 8'h00);
   endsequence

   AST_CMD_ONE_PERIOD: assert property (
      s_ref_next_rise |=> mem_cs_n == 2'h3 && {mem_ras_n, mem_cas_n, mem_we_n} == CMD_NOP)
      else $error("command stood past one memory clock");

endmodule

// *** tb/sdram_mem_model.sv ***
// behavioural memory on the far side: decodes and logs commands
module sdram_mem_model
   import sdram_cfg_pkg::*;
(
   input  wire logic        mem_clk,
   input  wire logic        cke,
   input  wire logic [1:0]  cs_n,
   input  wire logic [2:0]  cmd,
   input  wire logic [1:0]  ba,
   input  wire logic [12:0] ma,
   output int               n_cmd,
   output logic      [2:0]  last_cmd,
   output logic      [2:0]  prev_cmd,
   output logic      [1:0]  last_cs_n,
   output logic      [1:0]  last_ba,
   output logic      [12:0] last_ma
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      n_cmd = 0;
      last_cmd = CMD_NOP;
      prev_cmd = CMD_NOP;
   end
   // a real part ignores its command pins while clock enable is low
   always @(posedge mem_clk) begin
      if (cke === 1'b1 && cs_n !== 2'b11 && cmd !== CMD_NOP) begin
         n_cmd <= n_cmd + 1;
         prev_cmd <= last_cmd;
         last_cmd <= cmd;
         last_cs_n <= cs_n;
         last_ba <= ba;
         last_ma <= ma;
      end
   end
endmodule

// *** tb/tb_sdram_interface_config.sv ***
// self-checking bench of the sdram configuration block
`include "sdram_cfg_params.svh"
module tb_sdram_interface_config;
   timeunit 1ns;
   timeprecision 1ps;
   import sdram_cfg_pkg::*;
   logic        clk, rstn, soft_rst, rd, wr, mclk, done, cke, ras_n, cas_n, we_n;
   logic        req, we, burst, cs;
   logic [8:0]  addr;
   logic [31:0] wdata, rdata, q;
   logic        wait_q;
   logic [1:0]  bank, cs_n, ba, dq_oe, l_cs, l_ba;
   logic [12:0] row, ma, l_ma;
   logic [9:0]  col;
   logic [3:0]  dqs_oe;
   logic [2:0]  l_cmd, p_cmd;
   int          n_cmd, fail_count, n_checks;

   sdram_interface_config uut (.clk(clk), .rstn(rstn), .soft_rst(soft_rst),
      .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wait_q),
      .acc_req(req), .acc_we(we), .acc_burst(burst), .acc_cs(cs), .acc_bank(bank),
      .acc_row(row), .acc_col(col), .acc_done(done), .mem_clk_in(mclk), .mem_cke(cke),
      .mem_cs_n(cs_n), .mem_ras_n(ras_n), .mem_cas_n(cas_n), .mem_we_n(we_n),
      .bank_select_pins(ba), .multiplexed_row_col_pins(ma), .mem_dq_oe(dq_oe),
      .data_strobe_pins_oe(dqs_oe));
   sdram_mem_model mdl (.mem_clk(mclk), .cke(cke), .cs_n(cs_n),
      .cmd({ras_n, cas_n, we_n}), .ba(ba), .ma(ma), .n_cmd(n_cmd), .last_cmd(l_cmd),
      .prev_cmd(p_cmd), .last_cs_n(l_cs), .last_ba(l_ba), .last_ma(l_ma));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // memory clock free-running, phase unrelated to clk
   initial begin
      mclk = 1'b0;
      #37;
      forever #100 mclk = ~mclk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic give_up;
      fail_count++;
      tally_and_finish();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // the request stands until the rising edge that samples waitrequest low
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      int k;
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wait_q !== 1'b0 && k < 60);
      if (wait_q !== 1'b0) give_up();
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      check(q, exp);
   endtask
   task automatic wait_cmd(input int target);
      int k;
      k = 0;
      while (n_cmd < target && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (n_cmd < target) give_up();
   endtask
   task automatic t_reset;
      check(cke, 1'b0);
      check(cs_n, 2'b11);
      rd_chk(`A_CTRL, `CTRL_RST);
      rd_chk(`A_TIM2, `TIM_RST);
   endtask
   task automatic t_setup;
      bus(1'b1, `A_SDLY, 32'h00000004);
      rd_chk(`A_SDLY, 32'h00000004 & `SDLY_MASK);
      bus(1'b1, `A_TIM1, 32'h2222A31F);
      rd_chk(`A_TIM1, 32'h2222A31F & `TIM1_MASK);
      bus(1'b1, `A_TIM2, 32'h22270000);
      rd_chk(`A_TIM2, 32'h22270000);
      rd_chk(9'h1F0, 32'h00000000);
   endtask
   task automatic t_locked;
      int c;
      bus(1'b1, `A_CTRL, 32'h40000000);
      // clock enable lands one cycle after the control register
      @(posedge clk);
      check(cke, 1'b1);
      c = n_cmd;
      bus(1'b1, `A_MODE, 32'h40010000);
      bus(1'b1, `A_CTRL, 32'h40000006);
      repeat (80) @(posedge clk);
      check(n_cmd, c);
   endtask
   task automatic t_mode;
      int c;
      bus(1'b1, `A_CTRL, 32'hC0000000);
      c = n_cmd;
      bus(1'b1, `A_MODE, {2'b01, 12'hABC, 2'b01, 16'h0000});
      wait_cmd(c + 1);
      check(l_cmd, CMD_LMR);
      check(l_cs, 2'b00);
      check({l_ba, l_ma[11:0]}, {2'b01, 12'hABC});
      bus(1'b1, `A_MODE, 32'h6AF00000);
      repeat (80) @(posedge clk);
      check(n_cmd, c + 1);
   endtask
   task automatic t_soft;
      int c;
      c = n_cmd;
      bus(1'b1, `A_CTRL, 32'hC0000002);
      wait_cmd(c + 1);
      check({l_cmd, l_cs, l_ma[10]}, {CMD_PRE, 2'b00, 1'b1});
      rd_chk(`A_CTRL, 32'hC0000000);
      bus(1'b1, `A_CTRL, 32'hC0000004);
      wait_cmd(c + 2);
      check(l_cmd, CMD_REF);
      rd_chk(`A_CTRL, 32'hC0000000);
   endtask
   task automatic t_refresh;
      int c;
      c = n_cmd;
      bus(1'b1, `A_CTRL, 32'hD0010000);
      // 150 memory clocks: one refresh at enable, then one per 64 clocks
      repeat (1200) @(posedge clk);
      check(n_cmd - c, 3);
      bus(1'b1, `A_CTRL, 32'hC0000000);
   endtask
   task automatic t_access;
      int c, k;
      c = n_cmd;
      req <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (done !== 1'b1 && k < 400);
      if (done !== 1'b1) give_up();
      req <= 1'b0;
      wait_cmd(c + 2);
      check({p_cmd, l_cmd, l_ba, l_cs}, {CMD_ACT, CMD_RD, 2'b10, 2'b10});
      wait_cmd(c + 3);
      check({l_cmd, l_cs, l_ma[10]}, {CMD_PRE, 2'b10, 1'b0});
   endtask
   task automatic t_drive;
      bus(1'b1, `A_CTRL, 32'hC0402000);
      repeat (4) @(posedge clk);
      check(dq_oe, 2'b10);
      check(dqs_oe, 4'h0);
      bus(1'b1, `A_CTRL, 32'hE0402500);
      repeat (4) @(posedge clk);
      check(dqs_oe, 4'h5);
      bus(1'b1, `A_CTRL, 32'hC0000000);
      repeat (4) @(posedge clk);
      check(dq_oe, 2'b00);
   endtask
   task automatic t_soft_rst;
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      @(posedge clk);
      rd_chk(`A_CTRL, 32'hC0000000);
      rd_chk(`A_TIM1, `TIM_RST);
   endtask
   task automatic t_power_rst;
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      check(cke, 1'b0);
      check(cs_n, 2'b11);
      rstn <= 1'b1;
      @(posedge clk);
      rd_chk(`A_CTRL, `CTRL_RST);
   endtask

   initial begin
      rstn = 1'b0;
      soft_rst = 1'b0;
      {rd, wr, req, we, burst, cs} = 6'b000000;
      addr = 9'h000;
      wdata = 32'h00000000;
      bank = 2'b10;
      row = 13'h0155;
      col = 10'h02A;
      fail_count = 0;
      n_checks = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_setup();
      t_locked();
      t_mode();
      t_soft();
      t_refresh();
      t_access();
      t_drive();
      t_soft_rst();
      t_power_rst();
      tally_and_finish();
   end
endmodule
